// ==== sync_ctrl_pkg.sv ====
`default_nettype none
package sync_ctrl_pkg;

  // Serial port instruction layout
  localparam int unsigned INSTR_BITS    = 16;
  localparam int unsigned ADDR_BITS     = 13;
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [3:0]  INSTR_LAST    = 4'h000F;
  localparam logic [3:0]  BYTE_LAST     = 4'h0007;
  localparam logic [3:0]  CNT_RESET     = 4'h0000;

  // Register map
  localparam logic [12:0] SYNC_CTRL_ADDR  = 13'h003A;
  localparam logic [2:0]  SYNC_CTRL_RESET = 3'h0;
  localparam int unsigned MASTER_EN_BIT   = 0;
  localparam int unsigned DIV_SYNC_EN_BIT = 1;
  localparam int unsigned NEXT_ONLY_BIT   = 2;
  localparam int unsigned CTRL_BITS       = 3;

  typedef enum logic [1:0] {
    ST_INSTR,
    ST_WRITE,
    ST_READ
  } spi_state_type;

endpackage : sync_ctrl_pkg
`default_nettype wire

// ==== pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Asynchronous pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; the first is read only by the second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q       <= RST_VAL;
      pin_sync_out <= RST_VAL;
    end else begin
      meta_q       <= pin_in;
      pin_sync_out <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ==== clock_divider_sync_control.sv ====
// Functional notes
// - Master enable bit 0 gates all sync
// - Bit 1 gates sync pulses to divider
// - Bits 0,1 set, bit 2 clear: resync every pulse
// - Bit 2 set: align first pulse only
// - After one-shot sync, bit 1 self-clears
`timescale 1ns/1ps
`default_nettype none
module clock_divider_sync_control
  import sync_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Three-wire serial port
  input  wire logic spi_sclk,
  input  wire logic spi_cs_b,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe_b,
  // Sync pin
  input  wire logic sync_in,
  // Divider side
  output logic      sync_buffer_en,
  output logic      divider_sync
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0]       pins_s;
  logic             sclk_s;
  logic             cs_b_s;
  logic             sdio_s;
  logic             sync_s;
  logic             sclk_d_q;
  logic             sync_d_q;

  pin_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h0002)
  ) u_pin_sync (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .pin_in       ({sync_in, sdio_in, spi_cs_b, spi_sclk}),
    .pin_sync_out (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_b_s = pins_s[1];
  assign sdio_s = pins_s[2];
  assign sync_s = pins_s[3];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_q <= 1'b0;
      sync_d_q <= 1'b0;
    end else begin
      sclk_d_q <= sclk_s;
      sync_d_q <= sync_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [CTRL_BITS-1:0] ctrl_q;

  function automatic logic [DATA_BITS-1:0] reg_read(
    input logic [ADDR_BITS-1:0] addr,
    input logic [CTRL_BITS-1:0] ctrl
  );
    // Reserved bits and unmapped addresses read zero
    if (addr == SYNC_CTRL_ADDR) begin
      reg_read = {5'h0000, ctrl};
    end else begin
      reg_read = 8'h0000;
    end
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // Serial port slave, oversampled in the converter clock domain

  spi_state_type         state_q;
  logic [3:0]            cnt_q;
  logic [14:0]           shift_q;
  logic [ADDR_BITS-1:0]  addr_q;
  logic [DATA_BITS-1:0]  rd_shift_q;
  logic                  sdo_q;

  logic                  cs_act;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  instr_done;
  logic                  byte_done;
  logic                  wr_hit;
  logic [DATA_BITS-1:0]  wr_byte;
  logic [ADDR_BITS-1:0]  instr_addr;
  logic [ADDR_BITS-1:0]  addr_next;
  logic [DATA_BITS-1:0]  rd_byte;

  assign cs_act     = !cs_b_s;
  assign sclk_rise  = cs_act && sclk_s && !sclk_d_q;
  assign sclk_fall  = cs_act && !sclk_s && sclk_d_q;
  assign instr_done = sclk_rise && state_q == ST_INSTR
                      && cnt_q == INSTR_LAST;
  assign byte_done  = sclk_rise && state_q != ST_INSTR
                      && cnt_q == BYTE_LAST;
  assign wr_hit     = byte_done && state_q == ST_WRITE
                      && addr_q == SYNC_CTRL_ADDR;
  assign wr_byte    = {shift_q[6:0], sdio_s};
  assign instr_addr = {shift_q[11:0], sdio_s};
  // Streaming walks addresses downward
  assign addr_next  = ADDR_BITS'(addr_q - 1'b1);
  assign rd_byte    = reg_read(addr_q, ctrl_q);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_INSTR;
      cnt_q   <= CNT_RESET;
      shift_q <= 15'h0000;
      addr_q  <= 13'h0000;
    end else if (!cs_act) begin
      state_q <= ST_INSTR;
      cnt_q   <= CNT_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[13:0], sdio_s};
      cnt_q   <= 4'(cnt_q + 1'b1);
      if (instr_done) begin
        state_q <= shift_q[14] ? ST_READ : ST_WRITE;
        addr_q  <= instr_addr;
        cnt_q   <= CNT_RESET;
      end else if (byte_done) begin
        addr_q  <= addr_next;
        cnt_q   <= CNT_RESET;
      end
    end
  end

  // Read data changes on falling edges, host samples on rising
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_shift_q <= 8'h0000;
      sdo_q      <= 1'b0;
    end else if (instr_done) begin
      rd_shift_q <= reg_read(instr_addr, ctrl_q);
    end else if (byte_done) begin
      rd_shift_q <= reg_read(addr_next, ctrl_q);
    end else if (sclk_fall && state_q == ST_READ) begin
      sdo_q      <= rd_shift_q[7];
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
    end
  end

  assign sdio_out  = sdo_q;
  assign sdio_oe_b = !(cs_act && state_q == ST_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Sync control

  logic master_en;
  logic gate_open;
  logic sync_rise;
  logic one_shot_hit;
  logic div_sync_q;

  assign master_en    = ctrl_q[MASTER_EN_BIT];
  // Buffer unpowered: the pin is not even looked at
  assign sync_rise    = master_en && sync_s && !sync_d_q;
  assign gate_open    = master_en && ctrl_q[DIV_SYNC_EN_BIT];
  assign one_shot_hit = gate_open && sync_rise
                        && ctrl_q[NEXT_ONLY_BIT];

  // A write in the same cycle wins: it is the newer intent
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= SYNC_CTRL_RESET;
    end else if (wr_hit) begin
      ctrl_q <= wr_byte[CTRL_BITS-1:0];
    end else if (one_shot_hit) begin
      ctrl_q[DIV_SYNC_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_sync_q <= 1'b0;
    end else begin
      div_sync_q <= gate_open && sync_rise;
    end
  end

  assign sync_buffer_en = master_en;
  assign divider_sync   = div_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Register as software would read it back
  logic [DATA_BITS-1:0] ctrl_view;

  assign ctrl_view = reg_read(SYNC_CTRL_ADDR, ctrl_q);

  sequence s_first_pulse;
    sync_rise && gate_open && ctrl_q[NEXT_ONLY_BIT] && !wr_hit;
  endsequence

  sequence s_quiet2;
    !wr_hit ##1 !wr_hit;
  endsequence

  property p_master_gate;
    @(posedge sys_clk) disable iff (!rst_b)
      divider_sync |-> $past(sync_buffer_en) && $past(sync_s && !sync_d_q);
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("divider sync without master enable");

  property p_gate_closed;
    @(posedge sys_clk) disable iff (!rst_b)
      (sync_s && !sync_d_q && !ctrl_q[DIV_SYNC_EN_BIT]) |=> !divider_sync;
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("sync passed while gate closed");

  property p_continuous;
    @(posedge sys_clk) disable iff (!rst_b)
      (sync_s && !sync_d_q && master_en && ctrl_q[DIV_SYNC_EN_BIT]
       && !ctrl_q[NEXT_ONLY_BIT] && !wr_hit)
      |=> divider_sync && ctrl_q[DIV_SYNC_EN_BIT];
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous mode missed a pulse");

  property p_one_shot;
    @(posedge sys_clk) disable iff (!rst_b)
      s_first_pulse ##1 s_quiet2 |-> !gate_open && !divider_sync;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot mode passed a later pulse");

  property p_one_shot_first;
    @(posedge sys_clk) disable iff (!rst_b)
      s_first_pulse |=> divider_sync;
  endproperty
  a_one_shot_first: assert property (p_one_shot_first)
    else $error("one-shot mode missed the first pulse");

  property p_self_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      s_first_pulse |=> !ctrl_q[DIV_SYNC_EN_BIT]
        && !ctrl_view[DIV_SYNC_EN_BIT];
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("sync enable did not self-clear");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!rst_b)
      (instr_done || byte_done)
      |=> rd_shift_q[7:3] == 5'h0000 && rd_byte[7:3] == 5'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_write_lands;
    @(posedge sys_clk) disable iff (!rst_b)
      wr_hit |=> ctrl_q == $past(wr_byte[2:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write to sync control lost");

endmodule : clock_divider_sync_control
`default_nettype wire

// ==== sync_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial port pins
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_b,
  // Sync pin
  output logic      sync_in
);
  logic drive_q;
  logic bit_q;
  logic last_q;
  ////////////////////////////////////////////////////////////////////////////
  // Released line toggles, so a stale level can never pass for data
  always_comb begin
    if (!sdio_oe_b) sdio_in = sdio_out;
    else if (drive_q) sdio_in = bit_q;
    else sdio_in = ~last_q;
  end
  always @(posedge sys_clk) last_q <= sdio_in;
  // Idle: clock still, no frame, sync pin left low
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    drive_q  = 1'b1;
    bit_q    = 1'b0;
    last_q   = 1'b0;
    sync_in  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // One-byte frame; phases of 5 cycles leave margin over the 3 required
  task automatic xfer(input logic rd, input logic [12:0] addr,
                      input logic [7:0] wdat, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, 2'b00, addr, wdat};
    rdat = 8'h00;
    @(posedge sys_clk);
    spi_cs_b <= 1'b0;
    tick(4);
    for (int i = 23; i >= 0; i--) begin
      drive_q <= !(rd && i < 8);
      bit_q   <= frame[i];
      tick(5);
      spi_sclk <= 1'b1;
      if (i < 8) rdat[i] = sdio_in;
      tick(5);
      spi_sclk <= 1'b0;
    end
    tick(5);
    spi_cs_b <= 1'b1;
    drive_q  <= 1'b1;
    tick(5);
  endtask : xfer
  task automatic pulse();
    @(posedge sys_clk);
    sync_in <= 1'b1;
    tick(3);
    sync_in <= 1'b0;
    tick(3);
  endtask : pulse
endmodule : sync_host_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sync_ctrl_pkg::*;
  logic sys_clk;
  logic rst_b;
  logic spi_sclk;
  logic spi_cs_b;
  logic sdio_in;
  logic sdio_out;
  logic sdio_oe_b;
  logic sync_in;
  logic sync_buffer_en;
  logic divider_sync;
  int   errors      = 0;
  int   comparisons = 0;
  int   pulses      = 0;
  ////////////////////////////////////////////////////////////////////////////
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  // Counts high cycles, so a stuck pulse shows as extra
  always @(posedge sys_clk) if (divider_sync === 1'b1) pulses++;
  clock_divider_sync_control clock_divider_sync_control_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk),
    .spi_cs_b(spi_cs_b), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_b(sdio_oe_b), .sync_in(sync_in),
    .sync_buffer_en(sync_buffer_en), .divider_sync(divider_sync));
  sync_host_model sync_host_model_i (
    .sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b),
    .sync_in(sync_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    sync_host_model_i.xfer(1'b0, a, d, unused);
  endtask : wr
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sync_host_model_i.xfer(1'b1, a, 8'h00, d);
    check("read data", d, exp);
  endtask : rd_chk
  task automatic sync_chk(input int n, input logic [7:0] exp);
    int start;
    start = pulses;
    repeat (n) sync_host_model_i.pulse();
    repeat (4) @(posedge sys_clk);
    check("divider pulses", 8'(pulses - start), exp);
  endtask : sync_chk
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(SYNC_CTRL_ADDR, 8'h00);
    check("buffer enable", {7'h00, sync_buffer_en}, 8'h00);
    check("output enable", {7'h00, sdio_oe_b}, 8'h01);
    sync_chk(2, 8'h00);
  endtask : t_reset
  task automatic t_gate();
    wr(SYNC_CTRL_ADDR, 8'h02);
    check("buffer enable", {7'h00, sync_buffer_en}, 8'h00);
    sync_chk(2, 8'h00);
    wr(SYNC_CTRL_ADDR, 8'h01);
    check("buffer enable", {7'h00, sync_buffer_en}, 8'h01);
    sync_chk(2, 8'h00);
  endtask : t_gate
  task automatic t_continuous();
    wr(SYNC_CTRL_ADDR, 8'hFB);
    rd_chk(SYNC_CTRL_ADDR, 8'h03);
    sync_chk(3, 8'h03);
  endtask : t_continuous
  task automatic t_one_shot();
    wr(SYNC_CTRL_ADDR, 8'h07);
    rd_chk(SYNC_CTRL_ADDR, 8'h07);
    sync_chk(3, 8'h01);
    rd_chk(SYNC_CTRL_ADDR, 8'h05);
    sync_chk(2, 8'h00);
  endtask : t_one_shot
  // Unmapped place: write ignored, reads zero, sync register untouched
  task automatic t_unmapped();
    wr(13'h003B, 8'hFF);
    rd_chk(13'h003B, 8'h00);
    rd_chk(SYNC_CTRL_ADDR, 8'h05);
  endtask : t_unmapped
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_gate();
    t_continuous();
    t_one_shot();
    t_unmapped();
    summarize();
  end
  // About 3000 cycles expected; generous margin before giving up
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
